//--- logic/ppp_pkg.sv
// Shared constants and carrier types for the parallel programming port.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
`default_nettype none
package ppp_pkg;
  // Core clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  // Mode-select codes {hi,lo}
  localparam logic [1:0] MODE_ADDR        = 2'h0;
  localparam logic [1:0] MODE_DATA        = 2'h1;
  localparam logic [1:0] MODE_CMD         = 2'h2;
  // Command bytes
  localparam logic [7:0] CMD_NOP          = 8'h00;
  localparam logic [7:0] CMD_RD_FUSE_LOCK = 8'h04;
  localparam logic [7:0] CMD_RD_SIG       = 8'h08;
  localparam logic [7:0] CMD_WR_FLASH     = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM    = 8'h11;
  localparam logic [7:0] CMD_WR_LOCK      = 8'h20;
  localparam logic [7:0] CMD_WR_FUSE      = 8'h40;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h80;
  // Reset values of the nonvolatile bytes (all unprogrammed)
  localparam logic [7:0] FUSE_RESET       = 8'hff;
  localparam logic [7:0] LOCK_RESET       = 8'hff;
  localparam logic [7:0] ERASED_BYTE      = 8'hff;
  // Lock byte field positions
  localparam int unsigned LOCK_ONE_POS    = 0;
  localparam int unsigned LOCK_TWO_POS    = 1;
  localparam logic [7:0] BOOT_LOCK_MASK   = 8'h3c;
  // Signature address range
  localparam logic [7:0] SIG_LAST_ADDR    = 8'h02;
  localparam logic [7:0] CAL_ADDR         = 8'h00;
  // Program time (us) and chip erase time (us), minimum figures
  localparam int unsigned PROG_TIME_US    = 3700;
  localparam int unsigned ERASE_TIME_US   = 7500;
  localparam int unsigned PROG_CYCLES     = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_CYCLES    = ERASE_TIME_US * (CLK_HZ / 1_000_000);

  // Pin group sampled from the programmer
  typedef struct packed {
    logic [1:0] mode_sel;
    logic       byte_select_one;
    logic       byte_select_two;
    logic       page_latch_strobe;
    logic       write_strobe_n;
    logic       output_enable_n;
    logic       crystal_load_pin;
    logic [7:0] data;
  } ppp_pins_t;

  // Kind of nonvolatile operation in flight
  typedef enum logic [2:0] {
    PPP_OP_FLASH, PPP_OP_EEPROM, PPP_OP_FUSE, PPP_OP_LOCK, PPP_OP_ERASE
  } ppp_op_t;
endpackage
`default_nettype wire

//--- logic/ppp_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes the pins are stable levels relative to the core clock.
`default_nettype none
module ppp_sync #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  // First stage read only by the second stage; reset to the idle
  // levels so no false strobe edge appears after reset
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // ppp_sync

//--- logic/ppp_busy_timer.sv
// Countdown timer that holds busy for a programming or erase operation.
// Assumes start arrives only while idle; lengths come from the parent.
`default_nettype none
module ppp_busy_timer #(
  parameter int unsigned CW = 17
) (
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          start_i,
  input  wire logic [CW-1:0] len_i,
  output logic               busy_o,
  output logic               done_o
);
  logic [CW-1:0] cnt_q;

  // Count down; done pulses in the first cycle after busy falls
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else if (start_i && !busy_o) begin
      cnt_q  <= len_i;
      busy_o <= 1'b1;
      done_o <= 1'b0;
    end else if (busy_o) begin
      cnt_q  <= cnt_q - CW'(1);
      done_o <= (cnt_q == CW'(1));
      busy_o <= (cnt_q > CW'(1));
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule // ppp_busy_timer

//--- logic/ppp_port.sv
// Parallel programming port: command, address and data loading, page
// buffer, nonvolatile write sequencing and readback onto the data bus.
// Assumes programmer pins are asynchronous; they are synchronised here.
`default_nettype none
module ppp_port
  import ppp_pkg::*;
#(
  parameter int unsigned WORD_BITS   = 6,
  parameter int unsigned FLASH_PAGES = 256,
  parameter int unsigned EE_PAGES    = 64,
  parameter int unsigned EE_BITS     = 3,
  parameter int unsigned PROG_LEN    = PROG_CYCLES,
  parameter int unsigned ERASE_LEN   = ERASE_CYCLES,
  parameter logic [7:0]  SIG0        = 8'h3d, // Arbitrary identity value
  parameter logic [7:0]  SIG1        = 8'h55, // Arbitrary identity value
  parameter logic [7:0]  SIG2        = 8'h0a, // Arbitrary identity value
  parameter logic [7:0]  CAL_BYTE    = 8'h80
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire ppp_pkg::ppp_pins_t pins_i,
  output logic [7:0]            data_o,
  output logic                  data_oe_n_o,
  output logic                  ready_busy_flag_o,
  output logic [7:0]            fuse_low_o,
  output logic [7:0]            fuse_high_o,
  output logic [7:0]            fuse_ext_o,
  output logic [7:0]            lock_o,
  output logic                  nv_write_o,
  output logic [15:0]           nv_addr_o,
  output logic [15:0]           nv_data_o
);
  localparam int unsigned WORDS = 1 << WORD_BITS;
  localparam int unsigned EWRDS = 1 << EE_BITS;
  localparam int unsigned TW    = 17;
  // Idle pin levels: write strobe and output enable high, rest low
  localparam ppp_pins_t   PIN_IDLE = 16'h0600;

  ppp_pins_t  pin_s;
  logic       xtal_d1_q;
  logic       latch_d1_q;
  logic       wr_n_d1_q;
  logic       xtal_rise;
  logic       latch_rise;
  logic       wr_fall;
  logic       busy;
  logic       done;
  logic       start;
  logic [TW-1:0] start_len;
  logic [7:0] cmd_q;
  logic [7:0] addr_lo_q;
  logic [7:0] addr_hi_q;
  logic [7:0] data_lo_q;
  logic [7:0] data_hi_q;
  logic [15:0] page_buf_q [WORDS];
  logic [15:0] flash_q [FLASH_PAGES * WORDS];
  logic [7:0]  ee_q [EE_PAGES * EWRDS];
  logic        wr_en_q;
  ppp_op_t     op_q;
  logic [15:0] op_page_q;
  logic [1:0]  fuse_tgt_q;
  logic [7:0]  op_data_q;
  logic [7:0]  rd_byte;
  logic [WORD_BITS-1:0] buf_idx;

  // All programmer pins pass two flops before use
  ppp_sync #(
    .WIDTH   ($bits(ppp_pins_t)),
    .RST_VAL (PIN_IDLE)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (pins_i),
    .sync_o     (pin_s)
  );

  // Edge history of the synchronised strobes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      xtal_d1_q  <= 1'b0;
      latch_d1_q <= 1'b0;
      wr_n_d1_q  <= 1'b1;
    end else begin
      xtal_d1_q  <= pin_s.crystal_load_pin;
      latch_d1_q <= pin_s.page_latch_strobe;
      wr_n_d1_q  <= pin_s.write_strobe_n;
    end
  end

  // Strobe edges are dropped while a write is in flight
  assign xtal_rise  = pin_s.crystal_load_pin & ~xtal_d1_q & ~busy;
  assign latch_rise = pin_s.page_latch_strobe & ~latch_d1_q & ~busy;
  assign wr_fall    = ~pin_s.write_strobe_n & wr_n_d1_q & ~busy;

  // Command register; kept until a new one is loaded
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cmd_q <= CMD_NOP;
    end else if (xtal_rise && pin_s.mode_sel == MODE_CMD
                 && !pin_s.byte_select_one) begin
      cmd_q <= pin_s.data;
    end
  end

  // Address bytes; retained across operations
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      addr_lo_q <= 8'h00;
      addr_hi_q <= 8'h00;
    end else if (xtal_rise && pin_s.mode_sel == MODE_ADDR) begin
      if (pin_s.byte_select_one) begin
        addr_hi_q <= pin_s.data;
      end else begin
        addr_lo_q <= pin_s.data;
      end
    end
  end

  // Data bytes
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      data_lo_q <= 8'h00;
      data_hi_q <= 8'h00;
    end else if (xtal_rise && pin_s.mode_sel == MODE_DATA) begin
      if (pin_s.byte_select_one) begin
        data_hi_q <= pin_s.data;
      end else begin
        data_lo_q <= pin_s.data;
      end
    end
  end

  // Write enable follows the loaded command; no-op clears it
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wr_en_q <= 1'b0;
    end else if (xtal_rise && pin_s.mode_sel == MODE_CMD
                 && !pin_s.byte_select_one) begin
      wr_en_q <= (pin_s.data != CMD_NOP);
    end
  end

  // Word index; EEPROM pages are shorter, so fewer low bits count
  assign buf_idx = (cmd_q == CMD_WR_EEPROM)
                   ? WORD_BITS'(addr_lo_q[EE_BITS-1:0])
                   : addr_lo_q[WORD_BITS-1:0];

  // Page buffer; word index from low address bits
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < WORDS; i++) begin
        page_buf_q[i] <= {ERASED_BYTE, ERASED_BYTE};
      end
    end else if (latch_rise && pin_s.byte_select_one && wr_en_q
                 && (cmd_q == CMD_WR_FLASH || cmd_q == CMD_WR_EEPROM)) begin
      page_buf_q[buf_idx] <= {data_hi_q, data_lo_q};
    end
  end

  // Start of a nonvolatile operation on the write strobe
  always_comb begin
    start     = 1'b0;
    start_len = TW'(PROG_LEN);
    if (wr_fall && wr_en_q) begin
      case (cmd_q)
        CMD_WR_FLASH, CMD_WR_FUSE, CMD_WR_LOCK: start = 1'b1;
        CMD_WR_EEPROM: start = ~pin_s.byte_select_one;
        CMD_CHIP_ERASE: begin
          start     = 1'b1;
          start_len = TW'(ERASE_LEN);
        end
        default: start = 1'b0;
      endcase
    end
  end

  ppp_busy_timer #(.CW(TW)) u_timer (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .start_i    (start),
    .len_i      (start_len),
    .busy_o     (busy),
    .done_o     (done)
  );

  // Capture operation parameters at the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      op_q       <= PPP_OP_FLASH;
      op_page_q  <= 16'h0000;
      fuse_tgt_q <= 2'h0;
      op_data_q  <= 8'h00;
    end else if (start) begin
      op_page_q  <= {addr_hi_q, addr_lo_q};
      fuse_tgt_q <= {pin_s.byte_select_two, pin_s.byte_select_one};
      op_data_q  <= data_lo_q;
      case (cmd_q)
        CMD_WR_FLASH:   op_q <= PPP_OP_FLASH;
        CMD_WR_EEPROM:  op_q <= PPP_OP_EEPROM;
        CMD_WR_FUSE:    op_q <= PPP_OP_FUSE;
        CMD_WR_LOCK:    op_q <= PPP_OP_LOCK;
        default:        op_q <= PPP_OP_ERASE;
      endcase
    end
  end

  // Fuse bytes commit at the end of the busy time
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      fuse_low_o  <= FUSE_RESET;
      fuse_high_o <= FUSE_RESET;
      fuse_ext_o  <= FUSE_RESET;
    end else if (done && op_q == PPP_OP_FUSE) begin
      case (fuse_tgt_q)
        2'h0: fuse_low_o  <= op_data_q;
        2'h1: fuse_high_o <= op_data_q;
        2'h2: fuse_ext_o  <= op_data_q;
        default: fuse_low_o <= fuse_low_o;
      endcase
    end
  end

  // Lock bits only move toward programmed; erase clears them
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_o <= LOCK_RESET;
    end else if (done && op_q == PPP_OP_ERASE) begin
      lock_o <= LOCK_RESET;
    end else if (done && op_q == PPP_OP_LOCK) begin
      if (!lock_o[LOCK_ONE_POS] && !lock_o[LOCK_TWO_POS]) begin
        lock_o <= lock_o & (op_data_q | BOOT_LOCK_MASK);
      end else begin
        lock_o <= lock_o & op_data_q;
      end
    end
  end

  // Flash and EEPROM arrays written from the page buffer
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < FLASH_PAGES * WORDS; i++) begin
        flash_q[i] <= {ERASED_BYTE, ERASED_BYTE};
      end
      for (int i = 0; i < EE_PAGES * EWRDS; i++) begin
        ee_q[i] <= ERASED_BYTE;
      end
    end else if (done && op_q == PPP_OP_ERASE) begin
      for (int i = 0; i < FLASH_PAGES * WORDS; i++) begin
        flash_q[i] <= {ERASED_BYTE, ERASED_BYTE};
      end
      for (int i = 0; i < EE_PAGES * EWRDS; i++) begin
        ee_q[i] <= ERASED_BYTE;
      end
    end else if (done && op_q == PPP_OP_FLASH) begin
      for (int w = 0; w < WORDS; w++) begin
        // Page bits sit above the word bits in the address
        flash_q[(int'(op_page_q >> WORD_BITS) % FLASH_PAGES) * WORDS + w]
          <= page_buf_q[w];
      end
    end else if (done && op_q == PPP_OP_EEPROM) begin
      for (int w = 0; w < EWRDS; w++) begin
        ee_q[(int'(op_page_q >> EE_BITS) % EE_PAGES) * EWRDS + w]
          <= page_buf_q[w][7:0];
      end
    end
  end

  // Commit strobe toward the array macro
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      nv_write_o <= 1'b0;
      nv_addr_o  <= 16'h0000;
      nv_data_o  <= 16'h0000;
    end else begin
      nv_write_o <= done && (op_q == PPP_OP_FLASH || op_q == PPP_OP_EEPROM);
      nv_addr_o  <= op_page_q;
      nv_data_o  <= page_buf_q[0];
    end
  end

  // Readback selection per command and byte-selects
  always_comb begin
    rd_byte = ERASED_BYTE;
    case (cmd_q)
      CMD_RD_FUSE_LOCK: begin
        case ({pin_s.byte_select_two, pin_s.byte_select_one})
          2'h0: rd_byte = fuse_low_o;
          2'h3: rd_byte = fuse_high_o;
          2'h2: rd_byte = fuse_ext_o;
          default: rd_byte = lock_o;
        endcase
      end
      CMD_RD_SIG: begin
        if (pin_s.byte_select_one) begin
          rd_byte = (addr_lo_q == CAL_ADDR) ? CAL_BYTE : ERASED_BYTE;
        end else begin
          case (addr_lo_q)
            8'h00: rd_byte = SIG0;
            8'h01: rd_byte = SIG1;
            SIG_LAST_ADDR: rd_byte = SIG2;
            default: rd_byte = ERASED_BYTE;
          endcase
        end
      end
      default: rd_byte = ERASED_BYTE;
    endcase
  end

  // Bus driver and ready flag, all registered
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      data_o            <= 8'h00;
      data_oe_n_o       <= 1'b1;
      ready_busy_flag_o <= 1'b1;
    end else begin
      data_o            <= rd_byte;
      data_oe_n_o       <= pin_s.output_enable_n;
      ready_busy_flag_o <= ~(busy | start);
    end
  end
endmodule // ppp_port
`default_nettype wire

//--- dv/ppp_port_props.sv
// Checker for the port: busy timing, bus drive, stored bytes.
// Assumes it is bound to ppp_port and sees only its ports.
`default_nettype none
module ppp_port_props #(
  parameter int unsigned PROG_LEN  = ppp_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_LEN = ppp_pkg::ERASE_CYCLES
) (
  input wire logic               core_clk_i,
  input wire logic               rst_i,
  input wire ppp_pkg::ppp_pins_t pins_i,
  input wire logic [7:0]         data_o,
  input wire logic               data_oe_n_o,
  input wire logic               ready_busy_flag_o,
  input wire logic [7:0]         fuse_low_o,
  input wire logic [7:0]         fuse_high_o,
  input wire logic [7:0]         fuse_ext_o,
  input wire logic [7:0]         lock_o,
  input wire logic               nv_write_o,
  input wire logic [15:0]        nv_addr_o,
  input wire logic [15:0]        nv_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ppp_pkg::*;
  int unsigned busy_cnt_q;
  logic [7:0]  lock_prev_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // Busy length, cleared while ready
  always_ff @(posedge core_clk_i) begin
    if (rst_i || ready_busy_flag_o) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 1;
    end
  end

  // Previous lock byte; avoids $past on slices
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lock_prev_q <= LOCK_RESET;
    end else begin
      lock_prev_q <= lock_o;
    end
  end

  // Output enable held long enough to pass the synchroniser
  sequence s_oe_high;
    pins_i.output_enable_n [*5];
  endsequence
  sequence s_oe_low;
    !pins_i.output_enable_n [*5];
  endsequence

  chk_busy_length: assert property ($rose(ready_busy_flag_o) |->
    busy_cnt_q inside {[PROG_LEN-1:PROG_LEN+1], [ERASE_LEN-1:ERASE_LEN+1]})
    else $error("busy length wrong");
  chk_busy_cause: assert property ($fell(ready_busy_flag_o) |->
    (!$past(pins_i.write_strobe_n, 3) || !$past(pins_i.write_strobe_n, 4)
     || !$past(pins_i.write_strobe_n, 5)))
    else $error("busy without write strobe");
  chk_oe_release: assert property (s_oe_high |-> data_oe_n_o)
    else $error("bus driven with enable high");
  chk_oe_drive: assert property (s_oe_low |-> !data_oe_n_o)
    else $error("bus not driven with enable low");
  chk_commit_pulse: assert property (nv_write_o |=> !nv_write_o)
    else $error("commit pulse too long");
  chk_bytes_at_end: assert property (
    $changed({fuse_low_o, fuse_high_o, fuse_ext_o, lock_o})
    |-> $rose(ready_busy_flag_o))
    else $error("stored byte changed outside op end");
  chk_lock_only_down: assert property ((lock_o != lock_prev_q) |->
    ((lock_o & ~lock_prev_q) == 8'h00 || lock_o == LOCK_RESET))
    else $error("lock bit unprogrammed by write");
  chk_boot_lock_held: assert property (
    (lock_prev_q[1:0] == 2'h0 && lock_o != LOCK_RESET)
    |-> lock_o[5:2] == lock_prev_q[5:2])
    else $error("boot lock changed in mode 3");
endmodule // ppp_port_props

bind ppp_port ppp_port_props #(
  .PROG_LEN(PROG_LEN),
  .ERASE_LEN(ERASE_LEN)
) ppp_port_props_inst (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins_i),
  .data_o(data_o), .data_oe_n_o(data_oe_n_o),
  .ready_busy_flag_o(ready_busy_flag_o), .fuse_low_o(fuse_low_o),
  .fuse_high_o(fuse_high_o), .fuse_ext_o(fuse_ext_o), .lock_o(lock_o),
  .nv_write_o(nv_write_o), .nv_addr_o(nv_addr_o), .nv_data_o(nv_data_o)
);
`default_nettype wire

//--- dv/ppp_prog_model.sv
// Programmer model: drives the port's pins and resolves the data bus.
// Assumes a free-running core clock; pins change just after its edges.
`default_nettype none
module ppp_prog_model (
  input  wire logic               core_clk_i,
  input  wire logic [7:0]         data_i,
  input  wire logic               data_oe_n_i,
  input  wire logic               ready_busy_flag_i,
  output var  ppp_pkg::ppp_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import ppp_pkg::*;
  ppp_pins_t  pins_q = 16'h0600;  // Strobe and enable idle high
  logic       drive_q = 1'b1;
  logic [7:0] last_q = 8'h00;
  logic [7:0] bus;

  // Undriven bus toggles so a stale value never reads as valid
  assign bus = !data_oe_n_i ? data_i : (drive_q ? pins_q.data : ~last_q);
  always_ff @(posedge core_clk_i) last_q <= bus;
  always_comb begin
    pins_o      = pins_q;
    pins_o.data = bus;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Levels held 4 cycles so the synchroniser sees each one
  task automatic load_item(input logic [1:0] m, input logic b,
                           input logic [7:0] x);
    pins_q.mode_sel        <= m;
    pins_q.byte_select_one <= b;
    pins_q.data            <= x;
    hold(4);
    pins_q.crystal_load_pin <= 1'b1;
    hold(4);
    pins_q.crystal_load_pin <= 1'b0;
    hold(4);
  endtask

  task automatic latch_word();
    pins_q.byte_select_one <= 1'b1;
    hold(4);
    pins_q.page_latch_strobe <= 1'b1;
    hold(4);
    pins_q.page_latch_strobe <= 1'b0;
    hold(4);
  endtask

  task automatic strobe(input logic b1, input logic b2);
    pins_q.byte_select_one <= b1;
    pins_q.byte_select_two <= b2;
    hold(4);
    pins_q.write_strobe_n <= 1'b0;
    hold(5);
    pins_q.write_strobe_n <= 1'b1;
    hold(1);
  endtask

  // Count busy cycles; -1 when the bound runs out
  task automatic wait_ready(output int n);
    n = 0;
    while (!ready_busy_flag_i && n < 200) begin
      hold(1);
      n++;
    end
    if (n == 200) n = -1;
    pins_q.byte_select_one <= 1'b0;
    pins_q.byte_select_two <= 1'b0;
    hold(4);
  endtask

  task automatic read_byte(input logic b1, input logic b2,
                           output logic [7:0] v, output logic oe);
    pins_q.byte_select_one <= b1;
    pins_q.byte_select_two <= b2;
    pins_q.output_enable_n <= 1'b0;
    drive_q                <= 1'b0;
    hold(6);
    v  = bus;
    oe = data_oe_n_i;
    pins_q.output_enable_n <= 1'b1;
    hold(4);
    drive_q <= 1'b1;
    hold(1);
  endtask
endmodule // ppp_prog_model
`default_nettype wire

//--- dv/tb_top.sv
// Bench top: clock, reset, port, programmer model and scenarios.
// Assumes short busy lengths so each write takes a few dozen cycles.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ppp_pkg::*;
  localparam logic [7:0] SIG_A = 8'h3a; // Arbitrary value
  localparam logic [7:0] SIG_B = 8'hc5; // Arbitrary value
  localparam logic [7:0] SIG_C = 8'h71; // Arbitrary value
  localparam logic [7:0] CAL_V = 8'h6b;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  ppp_pins_t   pins;
  logic [7:0]  data_o, fuse_low_o, fuse_high_o, fuse_ext_o, lock_o, v;
  logic        data_oe_n_o, ready_busy_flag_o, nv_write_o, oe;
  logic [15:0] nv_addr_o, nv_data_o, nv_addr_seen, nv_data_seen;
  int          err_count = 0;
  int          checks_done = 0;
  int          nv_cnt = 0;
  int          n;
  logic [7:0]  fz [3] = '{8'h62, 8'hd9, 8'hfd};
  logic [7:0]  lk [3] = '{8'hfc, 8'hc3, 8'hff};
  logic [7:0]  sg [3] = '{SIG_A, SIG_B, SIG_C};

  initial forever #50 core_clk_i = ~core_clk_i;

  ppp_port #(.PROG_LEN(30), .ERASE_LEN(60), .SIG0(SIG_A), .SIG1(SIG_B),
    .SIG2(SIG_C), .CAL_BYTE(CAL_V)) ppp_port_inst (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .pins_i(pins), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .ready_busy_flag_o(ready_busy_flag_o),
    .fuse_low_o(fuse_low_o), .fuse_high_o(fuse_high_o),
    .fuse_ext_o(fuse_ext_o), .lock_o(lock_o), .nv_write_o(nv_write_o),
    .nv_addr_o(nv_addr_o), .nv_data_o(nv_data_o));
  ppp_prog_model ppp_prog_model_inst (.core_clk_i(core_clk_i),
    .data_i(data_o), .data_oe_n_i(data_oe_n_o),
    .ready_busy_flag_i(ready_busy_flag_o), .pins_o(pins));

  // Page commits seen at the storage side
  always @(posedge core_clk_i) begin
    if (nv_write_o === 1'b1) begin
      nv_cnt++;
      nv_addr_seen = nv_addr_o;
      nv_data_seen = nv_data_o;
    end
  end

  task automatic report_and_stop();
    if (err_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic ld(input logic [1:0] m, input logic b, input logic [7:0] x);
    ppp_prog_model_inst.load_item(m, b, x);
  endtask
  task automatic fin(input logic busy);
    ppp_prog_model_inst.wait_ready(n);
    if (n < 0) begin
      err_count++;
      report_and_stop();
    end
    `CHK("busy", busy, n > 0)
  endtask
  task automatic op(input logic b1, input logic b2, input logic busy);
    ppp_prog_model_inst.strobe(b1, b2);
    fin(busy);
  endtask
  task automatic rd(input logic b1, input logic b2, input logic [7:0] e);
    ppp_prog_model_inst.read_byte(b1, b2, v, oe);
    `CHK("rd_byte", e, v)
    `CHK("rd_oe_n", 1'b0, oe)
    `CHK("rel_oe_n", 1'b1, data_oe_n_o)
  endtask

  initial begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    `CHK("fuse_rst", FUSE_RESET, fuse_high_o)
    `CHK("ready_rst", 1'b1, ready_busy_flag_o)
    // Fuse targets low 0/0, high 1/0, extended 0/1
    for (int i = 0; i < 3; i++) begin
      ld(MODE_CMD, 1'b0, CMD_WR_FUSE);
      ld(MODE_DATA, 1'b0, fz[i]);
      op(i == 1, i == 2, 1'b1);
    end
    `CHK("fuse_ext", fz[2], fuse_ext_o)
    // Lock: mode 3, then boot bits refused, ones ignored
    ld(MODE_CMD, 1'b0, CMD_WR_LOCK);
    for (int i = 0; i < 3; i++) begin
      ld(MODE_DATA, 1'b0, lk[i]);
      op(1'b0, 1'b0, 1'b1);
    end
    `CHK("lock", 8'hfc, lock_o)
    ld(MODE_CMD, 1'b0, CMD_RD_FUSE_LOCK);
    rd(1'b0, 1'b0, fz[0]);
    rd(1'b1, 1'b1, fz[1]);
    rd(1'b0, 1'b1, fz[2]);
    rd(1'b1, 1'b0, 8'hfc);
    ld(MODE_CMD, 1'b0, CMD_RD_SIG);
    for (int a = 0; a < 3; a++) begin
      ld(MODE_ADDR, 1'b0, 8'(a));
      rd(1'b0, 1'b0, sg[a]);
    end
    ld(MODE_ADDR, 1'b0, CAL_ADDR);
    rd(1'b1, 1'b0, CAL_V);
    // Flash page; address load during busy must be ignored
    ld(MODE_CMD, 1'b0, CMD_WR_FLASH);
    ld(MODE_ADDR, 1'b0, 8'h40);
    ld(MODE_DATA, 1'b0, 8'h34);
    ld(MODE_DATA, 1'b1, 8'h12);
    ppp_prog_model_inst.latch_word();
    ld(MODE_ADDR, 1'b1, 8'h07);
    ppp_prog_model_inst.strobe(1'b0, 1'b0);
    ld(MODE_ADDR, 1'b1, 8'h0e);
    fin(1'b1);
    `CHK("nv_addr", 16'h0740, nv_addr_seen)
    `CHK("nv_data", 16'h1234, nv_data_seen)
    op(1'b0, 1'b0, 1'b1);
    `CHK("nv_addr2", 16'h0740, nv_addr_seen)
    ld(MODE_CMD, 1'b0, CMD_NOP);
    op(1'b0, 1'b0, 1'b0);
    `CHK("nv_cnt", 2, nv_cnt)
    // EEPROM page with byte select low at the strobe
    ld(MODE_CMD, 1'b0, CMD_WR_EEPROM);
    ld(MODE_ADDR, 1'b1, 8'h01);
    ld(MODE_ADDR, 1'b0, 8'h08);
    ld(MODE_DATA, 1'b0, 8'h5a);
    ppp_prog_model_inst.latch_word();
    op(1'b0, 1'b0, 1'b1);
    `CHK("ee_addr", 16'h0108, nv_addr_seen)
    `CHK("ee_data", 16'h125a, nv_data_seen)
    `CHK("ee_cnt", 3, nv_cnt)
    ld(MODE_CMD, 1'b0, CMD_CHIP_ERASE);
    op(1'b0, 1'b0, 1'b1);
    `CHK("lock_erased", LOCK_RESET, lock_o)
    `CHK("fuse_kept", fz[0], fuse_low_o)
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
